// ===== mbh_handler.v
// Write and diagnostics telegram handler over process images
`timescale 1ns/100ps
`default_nettype none
`include "mbh_consts.vh"
module mbh_handler #(
  parameter OUT_WORDS    = 16,
  parameter FLAG_WORDS   = 16,
  parameter IN_WORDS     = 16,
  parameter BUF_BYTES    = 32,
  parameter UNIT_BITS    = 8,
  parameter RESET_CYCLES = 16
) (
  input  wire                    mclk,
  input  wire                    rst_b,
  input  wire                    rxValid,
  input  wire [7:0]              rxData,
  input  wire                    rxLast,
  input  wire [7:0]              rxUnit,
  input  wire                    rxBroadcast,
  output wire                    rxReady,
  output wire                    txValid,
  output wire [7:0]              txData,
  output wire                    txLast,
  output wire [7:0]              txUnit,
  input  wire                    txReady,
  input  wire [IN_WORDS*16-1:0]  inImagePins,
  input  wire                    kbusErrPin,
  input  wire                    outLockPin,
  output wire [OUT_WORDS*16-1:0] outImage,
  output wire [FLAG_WORDS*16-1:0] flagImage,
  output wire                    socketClose,
  output wire                    selfTestReq,
  output wire                    resetBusy
);
  localparam S_RX    = 4'b0001;
  localparam S_EXEC  = 4'b0010;
  localparam S_SEND  = 4'b0100;
  localparam S_RESET = 4'b1000;
  localparam BW      = BUF_BYTES * 8;

  reg  [3:0]               state_q;
  reg  [BW-1:0]            qFlat_q, rFlat_q;
  reg  [7:0]               qCnt_q, unit_q, rLen_q, rIdx_q;
  reg                      qOvf_q, bcast_q, restart_q, sockClose_q, selfTest_q;
  reg  [15:0]              rstCnt_q, ansCnt_q, errCnt_q;
  reg  [OUT_WORDS*16-1:0]  out_q;
  reg  [FLAG_WORDS*16-1:0] flag_q;
  reg  [IN_WORDS*16-1:0]   inMeta_q, inSync_q;
  reg  [1:0]               kbusSync_q, lockSync_q;
  wire [15:0]              uAns, uNoAns, uErr;

  // Combinational execution results
  reg  [OUT_WORDS*16-1:0]  outD;
  reg  [FLAG_WORDS*16-1:0] flagD;
  reg  [BW-1:0]            rD;
  reg  [7:0]               rLenD, exc, fc, bc;
  reg                      noResp, clrCnt, doRestart, isWrite;
  reg  [15:0]              a1, a2, a3, a4, dv;
  integer                  i;

  function [15:0] qw;
    input [BW-1:0] f;
    input integer  k;
    begin
      qw = {f[k*8 +: 8], f[k*8+8 +: 8]};
    end
  endfunction

  function fits;
    input [15:0] a;
    input [15:0] l;
    input [15:0] b;
    input integer sz;
    begin
      fits = (a >= b) && (l != 16'h0000)
          && (({16'h0000, a} + {16'h0000, l}) <= ({16'h0000, b} + sz));
    end
  endfunction

  always @* begin
    outD      = out_q;
    flagD     = flag_q;
    rD        = {BW{1'b0}};
    rLenD     = 8'h05;
    exc       = 8'h00;
    noResp    = 1'b0;
    clrCnt    = 1'b0;
    doRestart = 1'b0;
    fc        = qFlat_q[7:0];
    a1        = qw(qFlat_q, 1);
    a2        = qw(qFlat_q, 3);
    a3        = qw(qFlat_q, 5);
    a4        = qw(qFlat_q, 7);
    bc        = qFlat_q[47:40];
    dv        = a2;
    isWrite   = (fc != `MBH_FC_DIAG);
    rD[39:0]  = qFlat_q[39:0];
    case (fc)
      `MBH_FC_WR_SINGLE: begin
        if (fits(a1, 16'h0001, `MBH_OUT_BASE, OUT_WORDS)) begin
          outD[(a1 - `MBH_OUT_BASE)*16 +: 16] = a2;
        end else if (fits(a1, 16'h0001, `MBH_FLAG_BASE, FLAG_WORDS)) begin
          flagD[(a1 - `MBH_FLAG_BASE)*16 +: 16] = a2;
        end else begin
          exc = `MBH_EXC_ADDR;
        end
      end
      `MBH_FC_DIAG: begin
        noResp = bcast_q;
        case (a1)
          `MBH_SUB_ECHO:     dv = a2;
          `MBH_SUB_RESTART: begin
            dv        = `MBH_RESTART_DATA;
            doRestart = ~bcast_q;
          end
          `MBH_SUB_CLR_CNT: begin
            dv     = a2;
            clrCnt = ~bcast_q;
          end
          `MBH_SUB_ANS_CNT:  dv = ansCnt_q;
          `MBH_SUB_ERR_CNT:  dv = errCnt_q;
          `MBH_SUB_UNIT_ANS: dv = uAns;
          `MBH_SUB_UNIT_NA:  dv = uNoAns;
          `MBH_SUB_UNIT_ERR: dv = uErr;
          default:           exc = `MBH_EXC_VALUE;
        endcase
        rD[39:24] = {dv[7:0], dv[15:8]};
      end
      `MBH_FC_WR_COILS: begin
        if (!fits(a1, a2, `MBH_COIL_BASE, OUT_WORDS * 16)) begin
          exc = `MBH_EXC_ADDR;
        end else if (({8'h00, bc} != ((a2 + 16'h0007) >> 3)) || (qCnt_q != 8'd6 + bc)) begin
          exc = `MBH_EXC_VALUE;
        end else begin
          for (i = 0; i < OUT_WORDS * 16; i = i + 1) begin
            if ((i >= a1) && (i < a1 + a2)) begin
              outD[i] = qFlat_q[48 + i - a1];
            end
          end
        end
      end
      `MBH_FC_WR_MULTI: begin
        if ((bc != {a2[6:0], 1'b0}) || (qCnt_q != 8'd6 + bc)) begin
          exc = `MBH_EXC_VALUE;
        end else if (fits(a1, a2, `MBH_OUT_BASE, OUT_WORDS)) begin
          for (i = 0; i < OUT_WORDS; i = i + 1) begin
            if ((i >= a1 - `MBH_OUT_BASE) && (i < a1 + a2 - `MBH_OUT_BASE)) begin
              outD[i*16 +: 16] = qw(qFlat_q, 6 + 2 * (i - (a1 - `MBH_OUT_BASE)));
            end
          end
        end else if (fits(a1, a2, `MBH_FLAG_BASE, FLAG_WORDS)) begin
          for (i = 0; i < FLAG_WORDS; i = i + 1) begin
            if ((i >= a1 - `MBH_FLAG_BASE) && (i < a1 + a2 - `MBH_FLAG_BASE)) begin
              flagD[i*16 +: 16] = qw(qFlat_q, 6 + 2 * (i - (a1 - `MBH_FLAG_BASE)));
            end
          end
        end else begin
          exc = `MBH_EXC_ADDR;
        end
      end
      `MBH_FC_RW_MULTI: begin
        bc = qFlat_q[79:72];
        if (!fits(a1, a2, `MBH_IN_BASE, IN_WORDS) || !fits(a3, a4, `MBH_OUT_BASE, OUT_WORDS)
            || (2 + 2 * a2 > BUF_BYTES)) begin
          exc = `MBH_EXC_ADDR;
        end else if ((bc != {a4[6:0], 1'b0}) || (qCnt_q != 8'd10 + bc)) begin
          exc = `MBH_EXC_VALUE;
        end else begin
          for (i = 0; i < OUT_WORDS; i = i + 1) begin
            if ((i >= a3 - `MBH_OUT_BASE) && (i < a3 + a4 - `MBH_OUT_BASE)) begin
              outD[i*16 +: 16] = qw(qFlat_q, 10 + 2 * (i - (a3 - `MBH_OUT_BASE)));
            end
          end
          rD[15:8] = {a2[6:0], 1'b0};
          rLenD    = 8'd2 + {a2[6:0], 1'b0};
          for (i = 0; i < IN_WORDS; i = i + 1) begin
            if ((i >= a1) && (i < a1 + a2)) begin
              rD[(2 + 2 * (i - a1))*8 +: 8] = inSync_q[i*16+8 +: 8];
              rD[(3 + 2 * (i - a1))*8 +: 8] = inSync_q[i*16 +: 8];
            end
          end
        end
      end
      default: exc = `MBH_EXC_FUNC;
    endcase
    if (exc == 8'h00) begin
      if (qOvf_q) begin
        exc = `MBH_EXC_VALUE;
      end else if (isWrite && kbusSync_q[1]) begin
        exc = `MBH_EXC_DEVICE;
      end else if (isWrite && lockSync_q[1]) begin
        exc = `MBH_EXC_BUSY;
      end
    end
    if (exc != 8'h00) begin
      outD      = out_q;
      flagD     = flag_q;
      clrCnt    = 1'b0;
      doRestart = 1'b0;
      rD        = {BW{1'b0}};
      rD[15:0]  = {exc, fc | `MBH_ERR_FLAG};
      rLenD     = 8'h02;
    end else if (fc == `MBH_FC_WR_COILS || fc == `MBH_FC_WR_MULTI) begin
      rD[39:0] = qFlat_q[39:0];
    end
    if (bcast_q) noResp = 1'b1;
  end

  wire execAns  = (state_q == S_EXEC) && !noResp;
  wire execErr  = execAns && (exc != 8'h00);
  wire execNone = (state_q == S_EXEC) && noResp;
  wire cntClr   = (state_q == S_EXEC) && (clrCnt || doRestart);
  mbh_unit_cnt #(.UNIT_BITS(UNIT_BITS)) uCnt (
    .mclk(mclk), .rst_b(rst_b), .clr(cntClr), .unitIdx(unit_q[UNIT_BITS-1:0]),
    .incAns(execAns), .incNoAns(execNone), .incErr(execErr),
    .ansCnt(uAns), .noAnsCnt(uNoAns), .errCnt(uErr));

  always @(posedge mclk) begin
    if (!rst_b) begin
      state_q     <= S_RX;
      qFlat_q     <= {BW{1'b0}};
      rFlat_q     <= {BW{1'b0}};
      {qCnt_q, unit_q, rLen_q, rIdx_q}                      <= 32'h0000_0000;
      {qOvf_q, bcast_q, restart_q, sockClose_q, selfTest_q} <= 5'h00;
      rstCnt_q    <= 16'h0000;
      out_q       <= {OUT_WORDS*16{1'b0}};
      flag_q      <= {FLAG_WORDS*16{1'b0}};
      ansCnt_q    <= `MBH_CNT_RST;
      errCnt_q    <= `MBH_CNT_RST;
      inMeta_q    <= {IN_WORDS*16{1'b0}};
      inSync_q    <= {IN_WORDS*16{1'b0}};
      {kbusSync_q, lockSync_q}                              <= 4'h0;
    end else begin
      inMeta_q    <= inImagePins;
      inSync_q    <= inMeta_q;
      kbusSync_q  <= {kbusSync_q[0], kbusErrPin};
      lockSync_q  <= {lockSync_q[0], outLockPin};
      sockClose_q <= 1'b0;
      selfTest_q  <= 1'b0;
      if (cntClr) begin
        ansCnt_q <= execAns ? 16'h0001 : `MBH_CNT_RST;
        errCnt_q <= `MBH_CNT_RST;
      end else begin
        ansCnt_q <= ansCnt_q + {15'h0000, execAns};
        errCnt_q <= errCnt_q + {15'h0000, execErr};
      end
      case (state_q)
        S_RX: begin
          if (rxValid) begin
            if (qCnt_q == 8'h00) begin
              unit_q  <= rxUnit;
              bcast_q <= rxBroadcast;
            end
            if (qCnt_q < BUF_BYTES) begin
              qFlat_q[qCnt_q*8 +: 8] <= rxData;
              qCnt_q                 <= qCnt_q + 8'h01;
            end else begin
              qOvf_q <= 1'b1;
            end
            if (rxLast) state_q <= S_EXEC;
          end
        end
        S_EXEC: begin
          out_q     <= outD;
          flag_q    <= flagD;
          rFlat_q   <= rD;
          rLen_q    <= rLenD;
          rIdx_q    <= 8'h00;
          restart_q <= doRestart;
          qCnt_q    <= 8'h00;
          qOvf_q    <= 1'b0;
          qFlat_q   <= {BW{1'b0}};
          state_q   <= noResp ? S_RX : S_SEND;
        end
        S_SEND: begin
          if (txReady) begin
            rFlat_q <= rFlat_q >> 8;
            rIdx_q  <= rIdx_q + 8'h01;
            if (rIdx_q == rLen_q - 8'h01) begin
              if (restart_q) begin
                sockClose_q <= 1'b1;
                selfTest_q  <= 1'b1;
                rstCnt_q    <= RESET_CYCLES[15:0];
                state_q     <= S_RESET;
              end else begin
                state_q <= S_RX;
              end
            end
          end
        end
        S_RESET: begin
          restart_q <= 1'b0;
          rstCnt_q  <= rstCnt_q - 16'h0001;
          if (rstCnt_q <= 16'h0001) state_q <= S_RX;
        end
        default: state_q <= S_RX;
      endcase
    end
  end

  assign rxReady     = (state_q == S_RX);
  assign txValid     = (state_q == S_SEND);
  assign txData      = rFlat_q[7:0];
  assign txLast      = (state_q == S_SEND) && (rIdx_q == rLen_q - 8'h01);
  assign txUnit      = unit_q;
  assign outImage    = out_q;
  assign flagImage   = flag_q;
  assign socketClose = sockClose_q;
  assign selfTestReq = selfTest_q;
  assign resetBusy   = (state_q == S_RESET);
endmodule // mbh_handler
`default_nettype wire

// ===== mbh_consts.vh
// Constants for the fieldbus write and diagnostics handler
`ifndef MBH_CONSTS_VH
`define MBH_CONSTS_VH
`define MBH_FC_WR_SINGLE 8'h06
`define MBH_FC_DIAG      8'h08
`define MBH_FC_WR_COILS  8'h0F
`define MBH_FC_WR_MULTI  8'h10
`define MBH_FC_RW_MULTI  8'h17
`define MBH_ERR_FLAG     8'h80
`define MBH_SUB_ECHO     16'h0000
`define MBH_SUB_RESTART  16'h0001
`define MBH_SUB_CLR_CNT  16'h000A
`define MBH_SUB_ANS_CNT  16'h000B
`define MBH_SUB_ERR_CNT  16'h000D
`define MBH_SUB_UNIT_ANS 16'h000E
`define MBH_SUB_UNIT_NA  16'h000F
`define MBH_SUB_UNIT_ERR 16'h0010
`define MBH_RESTART_DATA 16'h0000
`define MBH_EXC_FUNC     8'h01
`define MBH_EXC_ADDR     8'h02
`define MBH_EXC_VALUE    8'h03
`define MBH_EXC_DEVICE   8'h04
`define MBH_EXC_BUSY     8'h06
`define MBH_IN_BASE      16'h0000
`define MBH_OUT_BASE     16'h0800
`define MBH_FLAG_BASE    16'h4000
`define MBH_COIL_BASE    16'h0000
`define MBH_CNT_RST      16'h0000
`endif

// ===== mbh_unit_cnt.v
// Per-unit answer, no-answer and error-answer counters
`timescale 1ns/100ps
`default_nettype none
`include "mbh_consts.vh"
module mbh_unit_cnt #(
  parameter UNIT_BITS = 8
) (
  input  wire                 mclk,
  input  wire                 rst_b,
  input  wire                 clr,
  input  wire [UNIT_BITS-1:0] unitIdx,
  input  wire                 incAns,
  input  wire                 incNoAns,
  input  wire                 incErr,
  output wire [15:0]          ansCnt,
  output wire [15:0]          noAnsCnt,
  output wire [15:0]          errCnt
);
  localparam UNITS = 1 << UNIT_BITS;
  reg [15:0] ans_q   [0:UNITS-1];
  reg [15:0] noAns_q [0:UNITS-1];
  reg [15:0] err_q   [0:UNITS-1];
  integer    u;

  function [15:0] bump;
    input [15:0] cur;
    input        c;
    input        inc;
    begin
      if (c) begin
        bump = inc ? 16'h0001 : `MBH_CNT_RST;
      end else begin
        bump = cur + {15'h0000, inc};
      end
    end
  endfunction

  always @(posedge mclk) begin
    for (u = 0; u < UNITS; u = u + 1) begin
      if (!rst_b) begin
        ans_q[u]   <= `MBH_CNT_RST;
        noAns_q[u] <= `MBH_CNT_RST;
        err_q[u]   <= `MBH_CNT_RST;
      end else begin
        ans_q[u]   <= bump(ans_q[u], clr, incAns && (unitIdx == u[UNIT_BITS-1:0]));
        noAns_q[u] <= bump(noAns_q[u], clr, incNoAns && (unitIdx == u[UNIT_BITS-1:0]));
        err_q[u]   <= bump(err_q[u], clr, incErr && (unitIdx == u[UNIT_BITS-1:0]));
      end
    end
  end

  assign ansCnt   = ans_q[unitIdx];
  assign noAnsCnt = noAns_q[unitIdx];
  assign errCnt   = err_q[unitIdx];
endmodule // mbh_unit_cnt
`default_nettype wire

// ===== mbh_handler_chk.sv
// Assertion checker on the ports of the write and diagnostics handler
`timescale 1ns/100ps
`default_nettype none
module mbh_handler_chk #(
  parameter OUT_WORDS  = 16,
  parameter FLAG_WORDS = 16
) (
  input wire logic                     mclk,
  input wire logic                     rst_b,
  input wire logic                     rxValid,
  input wire logic                     rxLast,
  input wire logic                     rxBroadcast,
  input wire logic                     rxReady,
  input wire logic                     txValid,
  input wire logic [7:0]               txData,
  input wire logic                     txLast,
  input wire logic                     txReady,
  input wire logic [OUT_WORDS*16-1:0]  outImage,
  input wire logic [FLAG_WORDS*16-1:0] flagImage,
  input wire logic                     socketClose,
  input wire logic                     selfTestReq,
  input wire logic                     resetBusy
);
  logic midResp_q;
  logic midResp_d;
  // Inside a reply, past its first byte
  always_comb begin
    midResp_d = (txValid && txReady) ? !txLast : midResp_q;
  end
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      midResp_q <= 1'b0;
    end else begin
      midResp_q <= midResp_d;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_query_end;
    rxValid && rxReady && rxLast;
  endsequence
  sequence s_err_first;
    txValid && txReady && !midResp_q && txData[7];
  endsequence
  a_reply_prompt: assert property (s_query_end ##0 !rxBroadcast |-> ##2 txValid && !midResp_q)
    else $error("reply not offered two cycles after query end");
  a_bcast_silent: assert property (s_query_end ##0 rxBroadcast |=> !txValid [*4])
    else $error("broadcast query was answered");
  a_err_two_bytes: assert property (s_err_first |-> !txLast ##1 (txValid && txLast))
    else $error("error reply is not two bytes");
  a_tx_held: assert property (txValid && !txReady |=> txValid && $stable(txData) && $stable(txLast))
    else $error("reply byte changed before taken");
  a_no_rx_in_tx: assert property (txValid |-> !rxReady)
    else $error("query port ready during reply");
  a_close_pair: assert property (socketClose |-> selfTestReq && $past(txValid && txReady && txLast))
    else $error("socket close not right after last reply byte");
  a_busy_hold: assert property (socketClose |=> resetBusy [*8])
    else $error("restart hold too short");
  a_busy_quiet: assert property (resetBusy |-> !rxReady && !txValid)
    else $error("traffic during restart hold");
  a_image_exec: assert property (!$stable({outImage, flagImage}) |-> $past(!rxReady && !txValid))
    else $error("image changed outside execution");
endmodule // mbh_handler_chk
bind mbh_handler mbh_handler_chk #(.OUT_WORDS(OUT_WORDS), .FLAG_WORDS(FLAG_WORDS)) chk_u (
  .mclk(mclk), .rst_b(rst_b), .rxValid(rxValid), .rxLast(rxLast), .rxBroadcast(rxBroadcast),
  .rxReady(rxReady), .txValid(txValid), .txData(txData), .txLast(txLast), .txReady(txReady),
  .outImage(outImage), .flagImage(flagImage), .socketClose(socketClose),
  .selfTestReq(selfTestReq), .resetBusy(resetBusy));
`default_nettype wire

// ===== mbh_master_model.sv
// Remote master model: sends queries and takes replies
`timescale 1ns/100ps
`default_nettype none
module mbh_master_model (
  input  wire logic       mclk,
  input  wire logic       rxReady,
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  input  wire logic       txLast,
  output var  logic       rxValid,
  output var  logic [7:0] rxData,
  output var  logic       rxLast,
  output var  logic       txReady
);
  typedef logic [7:0] mbh_mq_t [$];
  logic stall = 1'b0;
  initial begin
    rxValid = 1'b0;
    rxData = 8'h00;
    rxLast = 1'b0;
    txReady = 1'b0;
  end
  task automatic xfer(input mbh_mq_t q, input bit wantReply, output mbh_mq_t r, output bit late);
    int n;
    int lim;
    bit done;
    r = {};
    done = 1'b0;
    late = 1'b0;
    rxValid = 1'b1;
    foreach (q[i]) begin
      rxData = q[i];
      rxLast = (i == q.size() - 1);
      n = 0;
      do begin
        @(posedge mclk);
        n++;
      end while (!rxReady && n < 64);
      late |= (n >= 64);
      #1;
    end
    rxValid = 1'b0;
    rxLast = 1'b0;
    rxData = ~rxData;
    lim = wantReply ? 256 : 12;
    for (n = 0; n < lim; n++) begin
      txReady = !(stall && n[0]);
      @(posedge mclk);
      if (txValid && txReady) begin
        r.push_back(txData);
        done = txLast;
      end
      #1;
      if (done) break;
    end
    txReady = 1'b0;
    late |= wantReply && !done;
  endtask
endmodule // mbh_master_model
`default_nettype wire

// ===== test_mbh_handler.sv
// Self-checking bench for the write and diagnostics handler
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module test_mbh_handler;
  typedef logic [7:0] mbh_bq_t [$];
  localparam int RST_CYC = 16;
  logic         mclk = 1'b0;
  logic         rst_b;
  logic         rxValid, rxLast, rxReady, rxBroadcast, txValid, txLast, txReady;
  logic [7:0]   rxData, rxUnit, txData, txUnit;
  logic [255:0] inImagePins, outImage, flagImage;
  logic         kbusErrPin, outLockPin, socketClose, selfTestReq, resetBusy;
  logic [31:0]  rngState = 32'h0000_0020;
  int           fail_count = 0;
  int           check_count = 0;
  int           closeCnt = 0;
  int           busyCnt = 0;
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    closeCnt += socketClose;
    busyCnt += resetBusy;
  end
  mbh_handler #(.UNIT_BITS(4), .RESET_CYCLES(RST_CYC)) dut_u (
    .mclk(mclk), .rst_b(rst_b), .rxValid(rxValid), .rxData(rxData), .rxLast(rxLast),
    .rxUnit(rxUnit), .rxBroadcast(rxBroadcast), .rxReady(rxReady), .txValid(txValid),
    .txData(txData), .txLast(txLast), .txUnit(txUnit), .txReady(txReady),
    .inImagePins(inImagePins), .kbusErrPin(kbusErrPin), .outLockPin(outLockPin),
    .outImage(outImage), .flagImage(flagImage), .socketClose(socketClose),
    .selfTestReq(selfTestReq), .resetBusy(resetBusy));
  mbh_master_model mm_u (
    .mclk(mclk), .rxReady(rxReady), .txValid(txValid), .txData(txData), .txLast(txLast),
    .rxValid(rxValid), .rxData(rxData), .rxLast(rxLast), .txReady(txReady));
  function automatic logic [31:0] rnd();
    rngState ^= rngState << 13;
    rngState ^= rngState >> 17;
    rngState ^= rngState << 5;
    return rngState;
  endfunction
  function automatic logic [15:0] img(input logic [15:0] a);
    if (a >= 16'h4000) return flagImage[(a - 16'h4000) * 16 +: 16];
    return outImage[(a - 16'h0800) * 16 +: 16];
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic run(input mbh_bq_t q, input bit bc, input logic [7:0] u, output mbh_bq_t r);
    bit late;
    logic [31:0] s;
    s = rnd();
    rxBroadcast = bc;
    rxUnit = u;
    mm_u.stall = s[0];
    mm_u.xfer(q, !bc, r, late);
    `CHK(late, 1'b0)
    `CHK(txUnit, u)
    if (late) wrap_up();
  endtask
  task automatic cmpq(input mbh_bq_t r, input mbh_bq_t e);
    `CHK(r.size(), e.size())
    foreach (e[i]) `CHK(r[i], e[i])
  endtask
  task automatic diag(input logic [15:0] s, input logic [15:0] d, input logic [7:0] u,
                      output logic [15:0] v);
    mbh_bq_t r;
    run({8'h08, s[15:8], s[7:0], d[15:8], d[7:0]}, 1'b0, u, r);
    `CHK({r[0], r[1], r[2]}, {8'h08, s})
    v = {r[3], r[4]};
  endtask
  initial begin
    mbh_bq_t q, r;
    logic [15:0] a, b, c, d, g0, g1, u0, u1, o0, o1;
    logic [31:0] w, pre;
    logic [7:0] exc [7];
    exc = '{8'h01, 8'h02, 8'h03, 8'h03, 8'h04, 8'h06, 8'h03};
    rst_b = 1'b0;
    rxUnit = 8'h00;
    rxBroadcast = 1'b0;
    kbusErrPin = 1'b0;
    outLockPin = 1'b0;
    for (int k = 0; k < 8; k++) inImagePins[k * 32 +: 32] = rnd();
    repeat (6) @(posedge mclk);
    #1 rst_b = 1'b1;
    for (int k = 0; k < 4; k++) begin
      w = rnd();
      a = (k[0] ? 16'h4000 : 16'h0800) + w[3:0];
      if (k == 0) a = 16'h0803;
      d = w[31:16];
      q = {8'h06, a[15:8], a[7:0], d[15:8], d[7:0]};
      run(q, 1'b0, 8'h01, r);
      cmpq(r, q);
      `CHK(img(a), d)
    end
    $display("single word writes done");
    a = 16'h080C;
    q = {8'h10, a[15:8], a[7:0], 8'h00, 8'h04, 8'h08};
    for (int k = 0; k < 2; k++) begin
      w = rnd();
      q = {q, w[31:24], w[23:16], w[15:8], w[7:0]};
    end
    run(q, 1'b0, 8'h01, r);
    cmpq(r, q[0:4]);
    for (int k = 0; k < 4; k++) `CHK(img(a + k), {q[6 + 2 * k], q[7 + 2 * k]})
    w = rnd();
    pre = outImage[31:0];
    q = {8'h0F, 8'h00, 8'h03, 8'h00, 8'h14, 8'h03, w[7:0], w[15:8], w[23:16]};
    run(q, 1'b0, 8'h01, r);
    cmpq(r, q[0:4]);
    pre[3 +: 20] = w[19:0];
    `CHK(outImage[31:0], pre)
    w = rnd();
    q = {8'h17, 8'h00, 8'h02, 8'h00, 8'h02, 8'h08, 8'h05, 8'h00, 8'h02, 8'h04,
         w[31:24], w[23:16], w[15:8], w[7:0]};
    run(q, 1'b0, 8'h01, r);
    a = inImagePins[47:32];
    b = inImagePins[63:48];
    cmpq(r, {8'h17, 8'h04, a[15:8], a[7:0], b[15:8], b[7:0]});
    `CHK({outImage[95:80], outImage[111:96]}, w)
    $display("multi writes done");
    w = rnd();
    diag(16'h0000, w[15:0], 8'h01, d);
    `CHK(d, w[15:0])
    diag(16'h000A, 16'h0000, 8'h01, d);
    `CHK(d, 16'h0000)
    diag(16'h000D, 16'h0000, 8'h01, d);
    `CHK(d, 16'h0000)
    diag(16'h000B, 16'h0000, 8'h01, a);
    diag(16'h000B, 16'h0000, 8'h01, b);
    `CHK(b - a, 16'h0001)
    diag(16'h000D, 16'h0000, 8'h01, g0);
    diag(16'h0010, 16'h0000, 8'h02, u0);
    diag(16'h000E, 16'h0000, 8'h07, o0);
    for (int k = 0; k < 7; k++) begin
      case (k)
        0: q = {8'h07, 8'h00, 8'h00, 8'h00, 8'h00};
        1: q = {8'h06, 8'h08, 8'h10, 8'h12, 8'h34};
        2: q = {8'h10, 8'h08, 8'h00, 8'h00, 8'h01, 8'h03, 8'h01, 8'h02, 8'h03};
        3: q = {8'h08, 8'h00, 8'h05, 8'h00, 8'h00};
        6: begin
          q = {8'h06, 8'h08, 8'h00, 8'h00, 8'h01};
          repeat (28) q.push_back(8'h5A);
        end
        default: q = {8'h06, 8'h08, 8'h00, 8'h55, 8'h55};
      endcase
      kbusErrPin = (k == 4);
      outLockPin = (k == 5);
      repeat (3) @(posedge mclk);
      #1 pre = outImage[31:0];
      run(q, 1'b0, 8'h02, r);
      cmpq(r, {q[0] | 8'h80, exc[k]});
      `CHK(outImage[31:0], pre)
    end
    kbusErrPin = 1'b0;
    outLockPin = 1'b0;
    diag(16'h000D, 16'h0000, 8'h01, g1);
    diag(16'h0010, 16'h0000, 8'h02, u1);
    diag(16'h000E, 16'h0000, 8'h07, o1);
    `CHK(g1 - g0, 16'h0007)
    `CHK(u1 - u0, 16'h0007)
    `CHK(o1 - o0, 16'h0001)
    $display("exceptions and counters done");
    diag(16'h000F, 16'h0000, 8'h05, a);
    d = rnd();
    run({8'h06, 8'h08, 8'h01, d[15:8], d[7:0]}, 1'b1, 8'h05, r);
    `CHK(r.size(), 0)
    run({8'h08, 8'h00, 8'h0A, 8'h00, 8'h00}, 1'b1, 8'h05, r);
    `CHK(r.size(), 0)
    diag(16'h000F, 16'h0000, 8'h05, b);
    `CHK(b - a, 16'h0002)
    `CHK(img(16'h0801), d)
    $display("broadcast done");
    diag(16'h0001, 16'h0000, 8'h01, d);
    `CHK(d, 16'h0000)
    diag(16'h000D, 16'h0000, 8'h01, c);
    `CHK(c, 16'h0000)
    `CHK(closeCnt, 1)
    `CHK(busyCnt, RST_CYC)
    $display("restart done");
    wrap_up();
  end
  initial begin
    repeat (90000) @(posedge mclk);
    fail_count++;
    wrap_up();
  end
endmodule // test_mbh_handler
`default_nettype wire
